// file: hw/wtc_regs.svh
`ifndef WTC_REGS_SVH
`define WTC_REGS_SVH

// ------------------------------------------------------------------
// register offsets (7-bit spi address)
// ------------------------------------------------------------------
`define WTC_ADDR_WAKE_PULL 7'h08
`define WTC_ADDR_BUS3 7'h0B
`define WTC_ADDR_TIMER 7'h0C
`define WTC_ADDR_HW1 7'h0E
`define WTC_ADDR_HW2 7'h0F
`define WTC_ADDR_GPIO 7'h17

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define WTC_WAKE_PULL_LSB 0
`define WTC_GPIO_PULL_LSB 6
`define WTC_CAN_FAST_BIT 4
`define WTC_TMR_ON_LSB 4
`define WTC_TMR_PER_LSB 0
`define WTC_UV_HYST_BIT 7
`define WTC_OT_RETRY_BIT 5
`define WTC_RST_DEL_BIT 4
`define WTC_LOCK0_BIT 3
`define WTC_LOCK1_BIT 0
`define WTC_GPIO_CFG_LSB 0

// ------------------------------------------------------------------
// reset values and field codes
// ------------------------------------------------------------------
`define WTC_RST_PULL 2'h0
`define WTC_RST_BIT 1'h0
`define WTC_RST_TMR_ON 3'h0
`define WTC_RST_TMR_PER 4'h0
`define WTC_RST_GPIO_CFG 3'h0
`define WTC_TON_HOLD_HIGH 3'h6
`define WTC_TON_RSVD 3'h7
`define WTC_GPIO_CYCLIC 3'h3
`define WTC_GPIO_WAKE 3'h5

// ------------------------------------------------------------------
// timing: base tick of 0.1 ms at 50 MHz
// ------------------------------------------------------------------
`define WTC_MCLK_MHZ 50
`define WTC_TICK_US 100
`define WTC_TICK_CYCLES (`WTC_TICK_US * `WTC_MCLK_MHZ)
`define WTC_TON1_US 100
`define WTC_TON2_US 300
`define WTC_TON3_US 1000
`define WTC_TON4_US 10000
`define WTC_TON5_US 20000
`define WTC_PER0_MS 10
`define WTC_PER1_MS 20
`define WTC_PER2_MS 50
`define WTC_PER3_MS 100
`define WTC_PER4_MS 200
`define WTC_PER5_MS 500
`define WTC_PER6_MS 1000
`define WTC_PER7_MS 2000
`define WTC_PER8_MS 5000
`define WTC_PER9_MS 10000
`define WTC_PER10_MS 20000
`define WTC_PER11_MS 50000
`define WTC_PER12_MS 100000
`define WTC_PER13_MS 200000
`define WTC_PER14_MS 500000
`define WTC_PER15_MS 1000000

`endif

// file: hw/wtc_pkg.sv
package wtc_pkg;

  typedef enum logic [1:0] {
    WTC_PULL_NONE = 2'h0,
    WTC_PULL_DOWN = 2'h1,
    WTC_PULL_UP = 2'h2,
    WTC_PULL_AUTO = 2'h3
  } wtc_pull_t;

  typedef enum logic [2:0] {
    WTC_TMR_IDLE = 3'h1,
    WTC_TMR_ON = 3'h2,
    WTC_TMR_OFF = 3'h4
  } wtc_tmr_state_t;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } wtc_frame_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_d;
    logic cs_d;
    logic [15:0] shift;
    logic [4:0] cnt;
    logic [7:0] tx;
    logic frame_valid;
    wtc_frame_t frame;
  } wtc_spi_state_t;

  typedef struct packed {
    wtc_pull_t wake_pin_bias;
    wtc_pull_t gpio_wake_bias;
    logic can_fast_mode;
    logic uv_reset_hyst_sel;
    logic overtemp_retry_ext;
    logic reset_delay_sel;
    logic lock_level_zero;
    logic lock_level_one;
    logic charge_pump_enable;
    logic [2:0] gpio_cfg;
  } wtc_cfg_t;

  typedef struct packed {
    wtc_pull_t wake_pin_pull_sel;
    wtc_pull_t gpio_wake_pull_sel;
    logic can_fast_mode;
    logic [2:0] timer_on_time;
    logic [3:0] timer_period;
    logic uv_reset_hyst_sel;
    logic overtemp_retry_ext;
    logic reset_delay_sel;
    logic lock_level_zero;
    logic lock_level_one;
    logic [2:0] gpio_cfg;
    logic charge_pump_enable;
    wtc_tmr_state_t tmr;
    logic [15:0] tick_cnt;
    logic [23:0] phase_cnt;
    logic hs_on;
    logic wake_evt;
  } wtc_state_t;

endpackage

// file: hw/wtc_spi_slave.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// spi slave: mode 0, 16-bit frames, msb first
// ------------------------------------------------------------------
module wtc_spi_slave (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_chip_select_b,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic frame_valid,
  output wtc_pkg::wtc_frame_t frame
);
  import wtc_pkg::*;

  wtc_spi_state_t st_reg;
  wtc_spi_state_t st_next;
  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = {spi_chip_select_b, spi_sclk, spi_mosi};
    st_next.sync2 = st_reg.sync1;
    st_next.sclk_d = st_reg.sync2[1];
    st_next.cs_d = st_reg.sync2[2];
    st_next.frame_valid = 1'b0;
    cs_act = ~st_reg.sync2[2];
    sclk_rise = st_reg.sync2[1] & ~st_reg.sclk_d;
    sclk_fall = ~st_reg.sync2[1] & st_reg.sclk_d;
    if (cs_act && st_reg.cs_d) begin
      st_next.cnt = 5'h00;
      st_next.tx = 8'h00;
    end else if (cs_act) begin
      if (sclk_rise) begin
        st_next.shift = {st_reg.shift[14:0], st_reg.sync2[0]};
        if (st_reg.cnt != 5'h1F) begin
          st_next.cnt = st_reg.cnt + 5'h01;
        end
      end else if (sclk_fall) begin
        if (st_reg.cnt == 5'h08) begin
          st_next.tx = rd_data;
        end else begin
          st_next.tx = {st_reg.tx[6:0], 1'b0};
        end
      end
    end else if (!st_reg.cs_d) begin
      // frames of any other length are dropped whole
      if (st_reg.cnt == 5'h10) begin
        st_next.frame_valid = 1'b1;
        st_next.frame = st_reg.shift;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // chip select resets to its idle level, so no false frame start follows reset
      st_reg <= '{
        sync1: 3'h4,
        sync2: 3'h4,
        sclk_d: 1'b0,
        cs_d: 1'b1,
        shift: 16'h0000,
        cnt: 5'h00,
        tx: 8'h00,
        frame_valid: 1'b0,
        frame: '0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_addr = st_reg.shift[6:0];
  assign spi_miso = st_reg.tx[7];
  assign spi_miso_oe = ~st_reg.cs_d;
  assign frame_valid = st_reg.frame_valid;
  assign frame = st_reg.frame;
endmodule // wtc_spi_slave

// file: hw/wtc_ctrl.sv
`timescale 1ns/1ps
`include "wtc_regs.svh"
module wtc_ctrl #(
  parameter int unsigned TICK_CYCLES = `WTC_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_chip_select_b,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic gpio_hs_cleared,
  input wire logic timer_wake_en,
  input wire logic charge_pump_enable_wr,
  input wire logic charge_pump_enable_wdata,
  output wtc_pkg::wtc_cfg_t cfg,
  output logic timer_hs_on,
  output logic cyclic_wake_evt
);
  import wtc_pkg::*;

  // ------------------------------------------------------------------
  // timing tables
  // ------------------------------------------------------------------
  function automatic logic [23:0] ms_ticks(input int unsigned ms);
    int unsigned t;
    t = (ms * 1000) / `WTC_TICK_US;
    return t[23:0];
  endfunction

  function automatic logic [23:0] us_ticks(input int unsigned us);
    int unsigned t;
    t = us / `WTC_TICK_US;
    return t[23:0];
  endfunction

  function automatic logic [23:0] period_ticks(input logic [3:0] code);
    logic [23:0] t;
    case (code)
      4'h0: t = ms_ticks(`WTC_PER0_MS);
      4'h1: t = ms_ticks(`WTC_PER1_MS);
      4'h2: t = ms_ticks(`WTC_PER2_MS);
      4'h3: t = ms_ticks(`WTC_PER3_MS);
      4'h4: t = ms_ticks(`WTC_PER4_MS);
      4'h5: t = ms_ticks(`WTC_PER5_MS);
      4'h6: t = ms_ticks(`WTC_PER6_MS);
      4'h7: t = ms_ticks(`WTC_PER7_MS);
      4'h8: t = ms_ticks(`WTC_PER8_MS);
      4'h9: t = ms_ticks(`WTC_PER9_MS);
      4'hA: t = ms_ticks(`WTC_PER10_MS);
      4'hB: t = ms_ticks(`WTC_PER11_MS);
      4'hC: t = ms_ticks(`WTC_PER12_MS);
      4'hD: t = ms_ticks(`WTC_PER13_MS);
      4'hE: t = ms_ticks(`WTC_PER14_MS);
      default: t = ms_ticks(`WTC_PER15_MS);
    endcase
    return t;
  endfunction

  function automatic logic [23:0] on_ticks(input logic [2:0] code);
    logic [23:0] t;
    case (code)
      3'h1: t = us_ticks(`WTC_TON1_US);
      3'h2: t = us_ticks(`WTC_TON2_US);
      3'h3: t = us_ticks(`WTC_TON3_US);
      3'h4: t = us_ticks(`WTC_TON4_US);
      3'h5: t = us_ticks(`WTC_TON5_US);
      default: t = 24'h000000;
    endcase
    return t;
  endfunction

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // ------------------------------------------------------------------
  // spi front end
  // ------------------------------------------------------------------
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic frame_valid;
  wtc_frame_t frame;

  wtc_spi_slave u_spi (
    .mclk(mclk),
    .rst_b(rst_b),
    .spi_chip_select_b(spi_chip_select_b),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .frame_valid(frame_valid),
    .frame(frame)
  );

  wtc_state_t st_reg;
  wtc_state_t st_next;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      `WTC_ADDR_WAKE_PULL: begin
        rd_data[`WTC_GPIO_PULL_LSB +: 2] = st_reg.gpio_wake_pull_sel;
        rd_data[`WTC_WAKE_PULL_LSB +: 2] = st_reg.wake_pin_pull_sel;
      end
      `WTC_ADDR_BUS3: begin
        rd_data[`WTC_CAN_FAST_BIT] = st_reg.can_fast_mode;
      end
      `WTC_ADDR_TIMER: begin
        rd_data[`WTC_TMR_ON_LSB +: 3] = st_reg.timer_on_time;
        rd_data[`WTC_TMR_PER_LSB +: 4] = st_reg.timer_period;
      end
      `WTC_ADDR_HW1: begin
        rd_data[`WTC_UV_HYST_BIT] = st_reg.uv_reset_hyst_sel;
        rd_data[`WTC_OT_RETRY_BIT] = st_reg.overtemp_retry_ext;
        rd_data[`WTC_RST_DEL_BIT] = st_reg.reset_delay_sel;
        rd_data[`WTC_LOCK0_BIT] = st_reg.lock_level_zero;
      end
      `WTC_ADDR_HW2: begin
        rd_data[`WTC_LOCK1_BIT] = st_reg.lock_level_one;
      end
      `WTC_ADDR_GPIO: begin
        rd_data[`WTC_GPIO_CFG_LSB +: 3] = st_reg.gpio_cfg;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // register and timer next state
  // ------------------------------------------------------------------
  logic wr;
  logic tmr_written;
  logic assigned;
  logic run_ok;
  logic tick;
  logic [23:0] phase_inc;

  always_comb begin
    st_next = st_reg;
    st_next.wake_evt = 1'b0;
    tmr_written = 1'b0;
    // only complete 16-bit frames commit, at chip select release
    wr = frame_valid && frame.write;
    if (soft_reset) begin
      st_next.wake_pin_pull_sel = WTC_PULL_NONE;
      st_next.gpio_wake_pull_sel = WTC_PULL_NONE;
      st_next.can_fast_mode = `WTC_RST_BIT;
      st_next.timer_on_time = `WTC_RST_TMR_ON;
      st_next.timer_period = `WTC_RST_TMR_PER;
      tmr_written = 1'b1;
      // restart value of the level-one bits is "unchanged"; here they clear unless the level-one lock is set
      if (!st_reg.lock_level_one) begin
        st_next.uv_reset_hyst_sel = `WTC_RST_BIT;
        st_next.overtemp_retry_ext = `WTC_RST_BIT;
        st_next.reset_delay_sel = `WTC_RST_BIT;
      end
      if (!st_reg.lock_level_zero) begin
        st_next.gpio_cfg = `WTC_RST_GPIO_CFG;
        st_next.charge_pump_enable = `WTC_RST_BIT;
      end
    end else if (restart_entry) begin
      // stale timer settings would fake a switch detection
      if (st_reg.gpio_cfg == `WTC_GPIO_CYCLIC && gpio_hs_cleared) begin
        st_next.timer_on_time = `WTC_RST_TMR_ON;
        st_next.timer_period = `WTC_RST_TMR_PER;
        tmr_written = 1'b1;
      end
    end else begin
      if (wr) begin
        case (frame.addr)
          `WTC_ADDR_WAKE_PULL: begin
            // reserved bits 5:2 are simply not stored
            st_next.wake_pin_pull_sel =
              wtc_pull_t'(frame.data[`WTC_WAKE_PULL_LSB +: 2]);
            st_next.gpio_wake_pull_sel =
              wtc_pull_t'(frame.data[`WTC_GPIO_PULL_LSB +: 2]);
          end
          `WTC_ADDR_BUS3: begin
            st_next.can_fast_mode = frame.data[`WTC_CAN_FAST_BIT];
          end
          `WTC_ADDR_TIMER: begin
            st_next.timer_on_time = frame.data[`WTC_TMR_ON_LSB +: 3];
            st_next.timer_period = frame.data[`WTC_TMR_PER_LSB +: 4];
            tmr_written = 1'b1;
          end
          `WTC_ADDR_HW1: begin
            if (!st_reg.lock_level_one) begin
              st_next.uv_reset_hyst_sel = frame.data[`WTC_UV_HYST_BIT];
              st_next.overtemp_retry_ext = frame.data[`WTC_OT_RETRY_BIT];
              st_next.reset_delay_sel = frame.data[`WTC_RST_DEL_BIT];
            end
            st_next.lock_level_zero = frame.data[`WTC_LOCK0_BIT];
          end
          `WTC_ADDR_HW2: begin
            // once set it also locks itself until power-up
            if (!st_reg.lock_level_one) begin
              st_next.lock_level_one = frame.data[`WTC_LOCK1_BIT];
            end
          end
          `WTC_ADDR_GPIO: begin
            if (!st_reg.lock_level_zero) begin
              st_next.gpio_cfg = frame.data[`WTC_GPIO_CFG_LSB +: 3];
            end
          end
          default: begin
          end
        endcase
      end
      if (charge_pump_enable_wr && !st_reg.lock_level_zero) begin
        st_next.charge_pump_enable = charge_pump_enable_wdata;
      end
    end

    // timer runs when owned by cyclic sense or cyclic wake and the on-time code is 1 to 5
    assigned = (st_next.gpio_cfg == `WTC_GPIO_CYCLIC) || timer_wake_en;
    run_ok = assigned && (on_ticks(st_next.timer_on_time) != 24'h000000);
    tick = (st_reg.tick_cnt >= TICK_LAST);
    phase_inc = st_reg.phase_cnt + 24'h000001;

    case (st_reg.tmr)
      WTC_TMR_IDLE: begin
        if (run_ok) begin
          st_next.tmr = WTC_TMR_ON;
          st_next.tick_cnt = 16'h0000;
          st_next.phase_cnt = 24'h000000;
        end
      end
      WTC_TMR_ON, WTC_TMR_OFF: begin
        st_next.tick_cnt = tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;
        if (tick) begin
          if (phase_inc >= period_ticks(st_reg.timer_period)) begin
            st_next.phase_cnt = 24'h000000;
            st_next.tmr = WTC_TMR_ON;
            st_next.wake_evt = timer_wake_en;
          end else begin
            st_next.phase_cnt = phase_inc;
            if (phase_inc >= on_ticks(st_reg.timer_on_time)) begin
              st_next.tmr = WTC_TMR_OFF;
            end
          end
        end
      end
      default: st_next.tmr = WTC_TMR_IDLE;
    endcase

    if (!run_ok) begin
      st_next.tmr = WTC_TMR_IDLE;
      st_next.tick_cnt = 16'h0000;
      st_next.phase_cnt = 24'h000000;
    end else if (tmr_written) begin
      // fresh settings restart the cycle at once
      st_next.tmr = WTC_TMR_ON;
      st_next.tick_cnt = 16'h0000;
      st_next.phase_cnt = 24'h000000;
    end

    st_next.hs_on = (st_next.tmr == WTC_TMR_ON) ||
      (st_next.timer_on_time == `WTC_TON_HOLD_HIGH);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{
        wake_pin_pull_sel: WTC_PULL_NONE,
        gpio_wake_pull_sel: WTC_PULL_NONE,
        can_fast_mode: `WTC_RST_BIT,
        timer_on_time: `WTC_RST_TMR_ON,
        timer_period: `WTC_RST_TMR_PER,
        uv_reset_hyst_sel: `WTC_RST_BIT,
        overtemp_retry_ext: `WTC_RST_BIT,
        reset_delay_sel: `WTC_RST_BIT,
        lock_level_zero: `WTC_RST_BIT,
        lock_level_one: `WTC_RST_BIT,
        gpio_cfg: `WTC_RST_GPIO_CFG,
        charge_pump_enable: `WTC_RST_BIT,
        tmr: WTC_TMR_IDLE,
        tick_cnt: 16'h0000,
        phase_cnt: 24'h000000,
        hs_on: 1'b0,
        wake_evt: 1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb begin
    cfg.wake_pin_bias = st_reg.wake_pin_pull_sel;
    // general pin bias only applies while it is a wake input
    cfg.gpio_wake_bias = (st_reg.gpio_cfg == `WTC_GPIO_WAKE) ?
      st_reg.gpio_wake_pull_sel : WTC_PULL_NONE;
    cfg.can_fast_mode = st_reg.can_fast_mode;
    cfg.uv_reset_hyst_sel = st_reg.uv_reset_hyst_sel;
    cfg.overtemp_retry_ext = st_reg.overtemp_retry_ext;
    cfg.reset_delay_sel = st_reg.reset_delay_sel;
    cfg.lock_level_zero = st_reg.lock_level_zero;
    cfg.lock_level_one = st_reg.lock_level_one;
    cfg.charge_pump_enable = st_reg.charge_pump_enable;
    cfg.gpio_cfg = st_reg.gpio_cfg;
  end

  assign timer_hs_on = st_reg.hs_on;
  assign cyclic_wake_evt = st_reg.wake_evt;
endmodule // wtc_ctrl

// file: test/wtc_ctrl_sva.sv
`timescale 1ns/1ps
// ------
// port checker
// ------
module wtc_ctrl_sva #(
  parameter int unsigned TICK_CYCLES = 5000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_chip_select_b,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic gpio_hs_cleared,
  input wire logic timer_wake_en,
  input wire logic charge_pump_enable_wr,
  input wire logic charge_pump_enable_wdata,
  input wire wtc_pkg::wtc_cfg_t cfg,
  input wire logic timer_hs_on,
  input wire logic cyclic_wake_evt
);
  import wtc_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ------
  // wake event spacing
  // ------
  // the shortest period is 10 ms, one hundred base ticks
  localparam int unsigned MIN_GAP = 100 * TICK_CYCLES - 1;
  logic [31:0] gap_cnt;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap_cnt <= 32'h00000000;
    end else if (cyclic_wake_evt) begin
      gap_cnt <= 32'h00000000;
    end else if (gap_cnt != 32'hFFFFFFFF) begin
      gap_cnt <= gap_cnt + 32'h00000001;
    end
  end

  evt_gap_a: assert property (cyclic_wake_evt |-> gap_cnt >= MIN_GAP)
    else $error("wake events closer than the shortest period");
  bias_gate_a: assert property (
    cfg.gpio_wake_bias != WTC_PULL_NONE |-> cfg.gpio_cfg == 3'h5)
    else $error("general pin bias outside wake mode");
  lock_one_hold_a: assert property (!$fell(cfg.lock_level_one))
    else $error("level one lock dropped");
  gpio_lock_a: assert property (
    $past(cfg.lock_level_zero) |-> $stable(cfg.gpio_cfg))
    else $error("pin config changed under lock");
  rwl_lock_a: assert property ($past(cfg.lock_level_one) |->
    $stable({cfg.uv_reset_hyst_sel, cfg.overtemp_retry_ext, cfg.reset_delay_sel}))
    else $error("locked bits changed");
  cp_write_a: assert property (
    charge_pump_enable_wr && !cfg.lock_level_zero && !soft_reset && !restart_entry
    |=> cfg.charge_pump_enable == $past(charge_pump_enable_wdata))
    else $error("charge pump write not taken");
  wake_src_a: assert property (cyclic_wake_evt |-> $past(timer_wake_en))
    else $error("wake event without timer wake source");
  restart_clr_a: assert property (
    restart_entry && gpio_hs_cleared && cfg.gpio_cfg == 3'h3 |-> ##[1:3] !timer_hs_on)
    else $error("timer output not stopped on restart");
  soft_keep_a: assert property (soft_reset |=> $stable(cfg.lock_level_zero) &&
    cfg.wake_pin_bias == WTC_PULL_NONE && !cfg.can_fast_mode)
    else $error("soft reset result wrong");
endmodule // wtc_ctrl_sva

bind wtc_ctrl wtc_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (
  .mclk, .rst_b, .spi_chip_select_b, .spi_sclk, .spi_mosi, .spi_miso, .spi_miso_oe,
  .soft_reset, .restart_entry, .gpio_hs_cleared, .timer_wake_en, .charge_pump_enable_wr,
  .charge_pump_enable_wdata, .cfg, .timer_hs_on, .cyclic_wake_evt);

// file: test/wtc_spi_host.sv
`timescale 1ns/1ps
// ------
// host side spi master, mode 0
// ------
module wtc_spi_host (
  input wire logic mclk,
  output logic cs_b,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  initial begin
    cs_b = 1'h1;
    sclk = 1'h0;
    mosi = 1'h0;
  end
  // four mclk per half period keeps clear of the three-cycle synchroniser minimum
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    @(posedge mclk) cs_b <= 1'h0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= w[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'h1;
      if (i < 8) r[i] = miso_oe ? miso : 1'hx;
      repeat (4) @(posedge mclk);
      sclk <= 1'h0;
    end
    repeat (4) @(posedge mclk);
    cs_b <= 1'h1;
    // idle data flips so a stale bit never looks valid
    mosi <= ~w[0];
    repeat (8) @(posedge mclk);
  endtask
endmodule // wtc_spi_host

// file: test/wake_timer_hw_config_regs_bench.sv
`timescale 1ns/1ps
module wake_timer_hw_config_regs_bench;
  import wtc_pkg::*;
  localparam int TK = 4;
  localparam logic [6:0] ADR [7] = '{7'h08, 7'h0B, 7'h0C, 7'h0E, 7'h17, 7'h10, 7'h0F};
  localparam int ONT [8] = '{0, 1, 3, 10, 100, 200, 500, 0};
  localparam int PER [4] = '{100, 200, 500, 1000};
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic soft_reset = 1'h0, restart_entry = 1'h0, gpio_hs_cleared = 1'h0;
  logic timer_wake_en = 1'h0, charge_pump_enable_wr = 1'h0, charge_pump_enable_wdata = 1'h0;
  logic cs_b, sclk, mosi, miso, miso_oe, timer_hs_on, cyclic_wake_evt;
  wtc_cfg_t cfg;
  int err_total = 0, total_checks = 0, seed = 32'h3e89b956, cpv = 0;
  int img [128];

  always #10 mclk = ~mclk;

  wtc_ctrl #(.TICK_CYCLES(TK)) dut_u (.mclk, .rst_b, .spi_chip_select_b(cs_b),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .soft_reset, .restart_entry, .gpio_hs_cleared, .timer_wake_en, .charge_pump_enable_wr,
    .charge_pump_enable_wdata, .cfg, .timer_hs_on, .cyclic_wake_evt);
  wtc_spi_host host_u (.mclk, .cs_b, .sclk, .mosi, .miso, .miso_oe);

  // ------
  // reference model and checks
  // ------
  task automatic chk(logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic int msk(logic [6:0] a);
    case (a)
      7'h08: return 8'hC3;
      7'h0B: return 8'h10;
      7'h0C: return 8'h7F;
      7'h0E: return 8'hB8;
      7'h0F: return 8'h01;
      7'h17: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(logic [6:0] a, logic [7:0] d);
    logic [7:0] r;
    int v;
    host_u.xfer({1'h1, a, d}, r);
    v = d & msk(a);
    if (a == 7'h0E && img[7'h0F][0]) v = (v & 8'h08) | (img[7'h0E] & 8'hB0);
    if (a == 7'h0F && img[7'h0F][0]) v = img[7'h0F];
    if (a == 7'h17 && img[7'h0E][3]) v = img[7'h17];
    img[a] = v;
  endtask
  task automatic rd(logic [6:0] a);
    logic [7:0] r;
    host_u.xfer({1'h0, a, 8'h00}, r);
    chk(img[a], {24'h000000, r});
  endtask
  task automatic chk_cfg();
    wtc_cfg_t e;
    e = {img[7'h08][1:0], (img[7'h17] == 32'h5 ? img[7'h08][7:6] : 2'h0),
      img[7'h0B][4], img[7'h0E][7], img[7'h0E][5:3], img[7'h0F][0], cpv[0], img[7'h17][2:0]};
    chk(32'(e), 32'(cfg));
  endtask
  task automatic rd_all();
    for (int i = 0; i < 7; i++) rd(ADR[i]);
    chk_cfg();
  endtask
  task automatic cp_wr(logic v);
    @(posedge mclk);
    charge_pump_enable_wr <= 1'h1;
    charge_pump_enable_wdata <= v;
    @(posedge mclk);
    charge_pump_enable_wr <= 1'h0;
    if (!img[7'h0E][3]) cpv = v;
  endtask
  task automatic pls(logic sr);
    @(posedge mclk);
    if (sr) soft_reset <= 1'h1;
    else restart_entry <= 1'h1;
    @(posedge mclk);
    soft_reset <= 1'h0;
    restart_entry <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask
  // full-period windows make the counts independent of the start phase
  task automatic meas(int w, int eh, int ee);
    int h, e;
    h = 0;
    e = 0;
    repeat (w) begin
      @(posedge mclk);
      h += (timer_hs_on === 1'h1);
      e += (cyclic_wake_evt === 1'h1);
    end
    chk(eh, h);
    chk(ee, e);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    test_done();
  end

  initial begin
    int n;
    for (int i = 0; i < 128; i++) img[i] = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (6) @(posedge mclk);
    rd_all();
    $display("reset values done");
    for (int k = 0; k < 40; k++) begin
      n = $random(seed);
      wr(ADR[n[15:8] % 8'h06], n[7:0]);
      cp_wr(n[16]);
      rd(ADR[n[15:8] % 8'h06]);
      chk_cfg();
    end
    $display("random access done");
    wr(7'h0E, 8'h00);
    wr(7'h17, 8'h05);
    for (int c = 0; c < 4; c++) begin
      wr(7'h08, {c[1:0], 4'h0, c[1:0]});
      chk_cfg();
    end
    $display("pull codes done");
    wr(7'h17, 8'h00);
    wr(7'h0C, 8'h10);
    meas(800, 0, 0);
    timer_wake_en <= 1'h1;
    wr(7'h0C, 8'h10);
    meas(800, 2 * TK, 2);
    wr(7'h17, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(7'h0C, {1'h0, c[2:0], 4'h2});
      meas(2000, ONT[c] * TK, int'(c > 0 && c < 6));
    end
    for (int p = 0; p < 4; p++) begin
      wr(7'h0C, {4'h1, p[3:0]});
      n = 4000 / (PER[p] * TK);
      meas(4000, n * TK, n);
    end
    $display("timer done");
    gpio_hs_cleared <= 1'h1;
    for (int g = 5; g >= 3; g -= 2) begin
      wr(7'h17, g[7:0]);
      wr(7'h0C, 8'h15);
      pls(1'h0);
      if (g == 3) img[7'h0C] = 0;
      rd(7'h0C);
    end
    $display("restart done");
    wr(7'h08, 8'hC3);
    wr(7'h0B, 8'h10);
    wr(7'h0E, 8'hB8);
    pls(1'h1);
    img[7'h08] = 0;
    img[7'h0B] = 0;
    img[7'h0C] = 0;
    img[7'h0E] = 8'h08;
    rd_all();
    wr(7'h0E, 8'hB0);
    wr(7'h0F, 8'h01);
    wr(7'h0E, 8'h48);
    wr(7'h0F, 8'h00);
    pls(1'h1);
    rd_all();
    $display("locks done");
    test_done();
  end
endmodule // wake_timer_hw_config_regs_bench
